//--- logic/tit_pkg.sv
package tit_pkg;

  // ----------------------------------------
  // Register port and map
  // ----------------------------------------
  localparam int         ADDR_W     = 8;
  localparam int         DATA_W     = 32;
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_INPUT  = 8'h04;
  localparam logic [7:0] OFS_GLOBAL = 8'h08;
  localparam logic [7:0] OFS_PERF   = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_INTG     = 0;
  localparam int CTRL_RAM_MODE = 1;
  localparam int CTRL_WNR      = 2;
  localparam int CTRL_OWNER    = 3;
  localparam int CTRL_UNIT_LO  = 4;
  localparam int UNIT_W        = 5;
  localparam int CTRL_USED_W   = 9;
  localparam int INPUT_DBG     = 0;
  localparam int GLB_NS        = 1;
  localparam int GLB_S         = 9;
  localparam int GLB_RAM_LO    = 16;
  localparam int RAM_FIELD_W   = 7;
  localparam int PERF_IDX_LO   = 16;
  localparam int PERF_WAY_LO   = 30;
  localparam int WAY_W         = 2;
  localparam int BUF_IDX_W     = 7;
  localparam int CRAM_AW       = 9;
  localparam int WORD_W_S2     = 98;
  localparam int WORD_W_S1     = 130;

  // ----------------------------------------
  // Events and reset values
  // ----------------------------------------
  localparam int          EV_DBG   = 0;
  localparam int          EV_WR    = 1;
  localparam int          EV_RD    = 2;
  localparam int          EV_W     = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] GLB_RST  = 32'h0000_0000;
  localparam logic [31:0] PERF_RST = 32'h0000_0000;
  localparam logic [2:0]  MASK_RST = 3'h0;

  typedef enum {TIT_IRQ_VEC, TIT_CTRL_RAM, TIT_BUF_RAM} tit_view_t;

endpackage

//--- logic/tit_sync3.sv
`timescale 1ns/1ns
module tit_sync3 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Level in and out
  input  wire logic d,
  output logic      q
);

  logic s1, s2, s3, next_q;

  // Change counts once the last two stages agree
  always_comb begin
    next_q = (s2 == s3) ? s3 : q;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q  <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= next_q;
    end
  end

endmodule // tit_sync3

//--- logic/tit_ctrl_ram.sv
`timescale 1ns/1ns
module tit_ctrl_ram
  import tit_pkg::*;
#(
  parameter int WORD_W = WORD_W_S1
) (
  // Clock
  input  wire logic                   clk,
  // Access
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  input  wire logic [CRAM_AW-1:0]     addr,
  input  wire logic [RAM_FIELD_W-1:0] wdata,
  output logic      [RAM_FIELD_W-1:0] rdata
);

  // No reset: contents are only meaningful once written
  logic [WORD_W-1:0] mem [2**CRAM_AW];

  // Field is the top bits of the word
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr][WORD_W-1 -: RAM_FIELD_W] <= wdata;
    end
  end

  // Nothing read while not enabled
  assign rdata = rd_en ? mem[addr][WORD_W-1 -: RAM_FIELD_W] : '0;

endmodule // tit_ctrl_ram

//--- logic/tit_integ_test.sv
`timescale 1ns/1ns
// Functional notes
// [RULE1] Input register bit 0 returns the synchronised debug enable pin; rest zero.
// [RULE2] Global register bit 9 drives the secure fault interrupt output.
// [RULE3] Global register bit 1 drives the non-secure fault interrupt output.
// [RULE4] RAM data field 22:16 active only with RAM access on and control owner.
// [RULE5] RAM field maps to top word bits, 97:91 or 129:123 by stage 1.
// [RULE6] Direction bit chooses read or write of the addressed RAM entry.
// [RULE7] RAM access off: index register is the buffer-unit interrupt enable vector.
// [RULE8] RAM access on, owner 0: index register gives control RAM index and way.
// [RULE9] RAM access on, owner 1: index register gives buffer-unit RAM index.
// [RULE10] Vector bit n enables performance interrupt of buffer unit n.
// [RULE11] Software writes enables only for buffer units that exist.
// [RULE12] Integration enable switches between functional and integration mode.
// [RULE13] RAM access off: no RAM bus drive and no RAM reads.
// [RULE14] Owner select picks control RAMs at 0, buffer-unit RAMs at 1.
// [RULE15] Forced fault outputs follow the bits only in integration mode.
module tit_integ_test
  import tit_pkg::*;
#(
  parameter bit STAGE1_PRESENT = 1'b1
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // Register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [DATA_W-1:0] reg_rdata,
  // Debug enable pin
  input  wire logic              secure_debug_enable_pin,
  // Functional fault interrupts
  input  wire logic              func_secure_fault,
  input  wire logic              func_nonsecure_fault,
  // Forced or passed fault interrupts
  output logic                   global_secure_fault_irq,
  output logic                   global_nonsecure_fault_irq,
  // Buffer-unit side
  output logic      [31:0]       buffer_unit_irq_en_out,
  output logic                   buffer_ram_active,
  output logic      [UNIT_W-1:0] buffer_ram_unit,
  output logic [BUF_IDX_W-1:0]   buffer_ram_index,
  // Interrupt
  output logic                   irq
);

  localparam int WORD_W = STAGE1_PRESENT ? WORD_W_S1 : WORD_W_S2;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [CTRL_USED_W-1:0] integration_control_reg;
  logic                   global_secure_fault_force;
  logic                   global_nonsecure_fault_force;
  logic [31:0]            perf_index;
  logic [EV_W-1:0]        status;
  logic [EV_W-1:0]        mask;
  logic                   dbg_prev;

  logic [CTRL_USED_W-1:0] next_ctrl;
  logic                   next_sf;
  logic                   next_nsf;
  logic [31:0]            next_perf;
  logic [EV_W-1:0]        next_status;
  logic [EV_W-1:0]        next_mask;
  logic [DATA_W-1:0]      next_rdata;
  logic                   next_secure_irq;
  logic                   next_nonsecure_irq;
  logic [31:0]            next_irq_en;
  logic                   next_buf_active;
  logic [UNIT_W-1:0]      next_buf_unit;
  logic [BUF_IDX_W-1:0]   next_buf_index;
  logic                   next_irq;

  logic                   dbg_level;
  logic                   integration_enable;
  logic                   ram_mode;
  logic                   ram_write_dir;
  logic                   ram_owner;
  tit_view_t              view;
  logic                   ram_ctrl_active;
  logic                   ram_wr;
  logic                   ram_rd;
  logic [CRAM_AW-1:0]     cram_addr;
  logic [RAM_FIELD_W-1:0] cram_rdata;
  logic [EV_W-1:0]        events;

  // Decoded write or read hit on one offset
  function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    return strobe && (a == ofs);
  endfunction

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  tit_sync3 u_sync (
    .clk   (clk),
    .reset (reset),
    .d     (secure_debug_enable_pin),
    .q     (dbg_level)
  );

  tit_ctrl_ram #(
    .WORD_W (WORD_W)
  ) u_cram (
    .clk   (clk),
    .wr_en (ram_wr),
    .rd_en (ram_rd),
    .addr  (cram_addr),
    .wdata (reg_wdata[GLB_RAM_LO +: RAM_FIELD_W]),
    .rdata (cram_rdata)
  );

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // [RULE12] Integration mode bit
  assign integration_enable = integration_control_reg[CTRL_INTG];
  assign ram_mode           = integration_control_reg[CTRL_RAM_MODE];
  assign ram_write_dir      = integration_control_reg[CTRL_WNR];
  assign ram_owner          = integration_control_reg[CTRL_OWNER];

  // [RULE14] Owner picks the view
  always_comb begin
    if (!ram_mode) begin
      view = TIT_IRQ_VEC;
    end else if (!ram_owner) begin
      view = TIT_CTRL_RAM;
    end else begin
      view = TIT_BUF_RAM;
    end
  end

  // [RULE4] [RULE13] RAM access gate
  assign ram_ctrl_active = (view == TIT_CTRL_RAM);

  // [RULE6] Direction steers access
  assign ram_wr = ram_ctrl_active && ram_write_dir
                  && hit(reg_write, reg_addr, OFS_GLOBAL);
  assign ram_rd = ram_ctrl_active && !ram_write_dir
                  && hit(reg_read, reg_addr, OFS_GLOBAL);

  // [RULE8] Control RAM way and index
  assign cram_addr = {perf_index[PERF_WAY_LO +: WAY_W],
                      perf_index[PERF_IDX_LO +: RAM_FIELD_W]};

  assign events = {ram_rd, ram_wr, dbg_level != dbg_prev};

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_comb begin
    next_ctrl   = integration_control_reg;
    next_sf     = global_secure_fault_force;
    next_nsf    = global_nonsecure_fault_force;
    next_perf   = perf_index;
    next_mask   = mask;
    next_status = status;
    if (hit(reg_write, reg_addr, OFS_CTRL)) begin
      next_ctrl = reg_wdata[CTRL_USED_W-1:0];
    end else if (hit(reg_write, reg_addr, OFS_GLOBAL)) begin
      // [RULE2] Secure force bit
      next_sf  = reg_wdata[GLB_S];
      // [RULE3] Non-secure force bit
      next_nsf = reg_wdata[GLB_NS];
    end else if (hit(reg_write, reg_addr, OFS_PERF)) begin
      next_perf = reg_wdata;
    end else if (hit(reg_write, reg_addr, OFS_STATUS)) begin
      next_status = status & ~reg_wdata[EV_W-1:0];
    end else if (hit(reg_write, reg_addr, OFS_MASK)) begin
      next_mask = reg_wdata[EV_W-1:0];
    end
    // New events win over a clear in the same cycle
    next_status = next_status | events;
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_comb begin
    next_rdata = '0;
    if (hit(reg_read, reg_addr, OFS_CTRL)) begin
      next_rdata[CTRL_USED_W-1:0] = integration_control_reg;
    end else if (hit(reg_read, reg_addr, OFS_INPUT)) begin
      // [RULE1] Debug enable level
      next_rdata[INPUT_DBG] = dbg_level;
    end else if (hit(reg_read, reg_addr, OFS_GLOBAL)) begin
      next_rdata[GLB_S]  = global_secure_fault_force;
      next_rdata[GLB_NS] = global_nonsecure_fault_force;
      // [RULE5] Top word bits from RAM
      next_rdata[GLB_RAM_LO +: RAM_FIELD_W] = cram_rdata;
    end else if (hit(reg_read, reg_addr, OFS_PERF)) begin
      next_rdata = perf_index;
    end else if (hit(reg_read, reg_addr, OFS_STATUS)) begin
      next_rdata[EV_W-1:0] = status;
    end else if (hit(reg_read, reg_addr, OFS_MASK)) begin
      next_rdata[EV_W-1:0] = mask;
    end
  end

  // ----------------------------------------
  // Output drive
  // ----------------------------------------
  always_comb begin
    // [RULE15] Functional values outside integration
    next_secure_irq    = integration_enable ? global_secure_fault_force
                                            : func_secure_fault;
    next_nonsecure_irq = integration_enable ? global_nonsecure_fault_force
                                            : func_nonsecure_fault;
    next_irq_en     = '0;
    next_buf_active = 1'b0;
    next_buf_unit   = '0;
    next_buf_index  = '0;
    case (view)
      // [RULE7] Enable vector view
      TIT_IRQ_VEC: begin
        // [RULE10] One enable per unit
        next_irq_en = perf_index;
      end
      // [RULE9] Buffer-unit RAM index
      TIT_BUF_RAM: begin
        next_buf_active = 1'b1;
        next_buf_unit   = integration_control_reg[CTRL_UNIT_LO +: UNIT_W];
        next_buf_index  = perf_index[BUF_IDX_W-1:0];
      end
      default: begin
        next_buf_active = 1'b0;
      end
    endcase
    next_irq = |(next_status & next_mask);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      integration_control_reg      <= CTRL_RST[CTRL_USED_W-1:0];
      global_secure_fault_force    <= GLB_RST[GLB_S];
      global_nonsecure_fault_force <= GLB_RST[GLB_NS];
      perf_index                   <= PERF_RST;
      status                       <= '0;
      mask                         <= MASK_RST;
      dbg_prev                     <= 1'b0;
      reg_rdata                    <= '0;
      global_secure_fault_irq      <= 1'b0;
      global_nonsecure_fault_irq   <= 1'b0;
      buffer_unit_irq_en_out       <= '0;
      buffer_ram_active            <= 1'b0;
      buffer_ram_unit              <= '0;
      buffer_ram_index             <= '0;
      irq                          <= 1'b0;
    end else begin
      integration_control_reg      <= next_ctrl;
      global_secure_fault_force    <= next_sf;
      global_nonsecure_fault_force <= next_nsf;
      perf_index                   <= next_perf;
      status                       <= next_status;
      mask                         <= next_mask;
      dbg_prev                     <= dbg_level;
      reg_rdata                    <= next_rdata;
      global_secure_fault_irq      <= next_secure_irq;
      global_nonsecure_fault_irq   <= next_nonsecure_irq;
      buffer_unit_irq_en_out       <= next_irq_en;
      buffer_ram_active            <= next_buf_active;
      buffer_ram_unit              <= next_buf_unit;
      buffer_ram_index             <= next_buf_index;
      irq                          <= next_irq;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  input_bit_a: assert property ( // [RULE1]
    hit(reg_read, reg_addr, OFS_INPUT) |=>
      reg_rdata == {31'h0, $past(dbg_level)})
    else $error("input register does not show debug level");

  secure_force_a: assert property ( // [RULE2]
    integration_enable && hit(reg_write, reg_addr, OFS_GLOBAL) ##1 integration_enable
      |=> global_secure_fault_irq == $past(reg_wdata[GLB_S], 2))
    else $error("secure fault output does not follow bit 9");

  nsec_force_a: assert property ( // [RULE3]
    integration_enable && hit(reg_write, reg_addr, OFS_GLOBAL) ##1 integration_enable
      |=> global_nonsecure_fault_irq == $past(reg_wdata[GLB_NS], 2))
    else $error("non-secure fault output does not follow bit 1");

  ram_gate_a: assert property ( // [RULE4]
    hit(reg_read, reg_addr, OFS_GLOBAL) && !ram_ctrl_active |=>
      reg_rdata[GLB_RAM_LO +: RAM_FIELD_W] == '0)
    else $error("RAM field visible while inactive");

  ram_dir_a: assert property ( // [RULE6]
    (ram_ctrl_active && ram_write_dir && hit(reg_write, reg_addr, OFS_GLOBAL)
      |=> status[EV_WR])
    and (ram_ctrl_active && !ram_write_dir && hit(reg_read, reg_addr, OFS_GLOBAL)
      |=> status[EV_RD]))
    else $error("RAM access against direction bit");

  no_ram_a: assert property ( // [RULE13]
    !ram_mode |-> !ram_wr && !ram_rd && cram_rdata == '0)
    else $error("RAM touched with access off");

  irq_vec_a: assert property ( // [RULE10]
    !ram_mode |=> buffer_unit_irq_en_out == $past(perf_index))
    else $error("enable vector not driven");

  buf_index_a: assert property ( // [RULE9]
    ram_mode && ram_owner |=>
      buffer_ram_active && buffer_ram_index == $past(perf_index[BUF_IDX_W-1:0]))
    else $error("buffer RAM index not driven");

  func_pass_a: assert property ( // [RULE15]
    !integration_enable |=> global_secure_fault_irq == $past(func_secure_fault)
      && global_nonsecure_fault_irq == $past(func_nonsecure_fault))
    else $error("functional fault not passed through");

endmodule // tit_integ_test

//--- verification/translation_unit_integration_test_test.sv
`timescale 1ns/1ns
module translation_unit_integration_test_test;
  import tit_pkg::*;

  logic                 clk;
  logic                 reset;
  logic [ADDR_W-1:0]    reg_addr;
  logic [DATA_W-1:0]    reg_wdata;
  logic                 reg_write;
  logic                 reg_read;
  logic [DATA_W-1:0]    reg_rdata;
  logic                 dbg_pin;
  logic                 f_s;
  logic                 f_ns;
  logic                 g_s;
  logic                 g_ns;
  logic [31:0]          en_out;
  logic                 bact;
  logic [UNIT_W-1:0]    bunit;
  logic [BUF_IDX_W-1:0] bidx;
  logic                 irq;
  int                   error_cnt;
  int                   comparisons;
  int                   cycles = 0;
  logic [31:0]          rv;
  logic [31:0]          v;
  logic [6:0]           ram_d [3];

  tit_integ_test DUT (
    .clk                        (clk),
    .reset                      (reset),
    .reg_addr                   (reg_addr),
    .reg_wdata                  (reg_wdata),
    .reg_write                  (reg_write),
    .reg_read                   (reg_read),
    .reg_rdata                  (reg_rdata),
    .secure_debug_enable_pin    (dbg_pin),
    .func_secure_fault          (f_s),
    .func_nonsecure_fault       (f_ns),
    .global_secure_fault_irq    (g_s),
    .global_nonsecure_fault_irq (g_ns),
    .buffer_unit_irq_en_out     (en_out),
    .buffer_ram_active          (bact),
    .buffer_ram_unit            (bunit),
    .buffer_ram_index           (bidx),
    .irq                        (irq)
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;

  // ----------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk_read(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t read data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t output %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic logic [31:0] ctrl_word(bit intg, bit ram, bit wnr, bit own,
                                            logic [4:0] unit);
    return {23'h0, unit, own, wnr, ram, intg};
  endfunction

  // Outside RAM mode only the two force bits read back
  function automatic logic [31:0] glb_expect(logic [31:0] w);
    return w & 32'h0000_0202;
  endfunction

  function automatic logic [31:0] ram_index(int i);
    return {i[1:0], 7'h0, 7'(8'h10 + i), 16'h0};
  endfunction

  // Hang guard, run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    dbg_pin = 1'b0;
    f_s = 1'b0;
    f_ns = 1'b0;
    error_cnt = 0;
    comparisons = 0;
    rv = $urandom(32'h5aafe7a6);
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk_out(en_out, 32'h0);
    chk_out({28'h0, g_s, g_ns, bact, irq}, 32'h0);
    rd(OFS_CTRL, rv);
    chk_read(rv, CTRL_RST);
    rd(OFS_PERF, rv);
    chk_read(rv, PERF_RST);
    rd(OFS_MASK, rv);
    chk_read(rv, {29'h0, MASK_RST});
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      @(posedge clk);
      dbg_pin <= (i < 2) ? (i == 0) : v[0];
      settle(6);
      rd(OFS_INPUT, rv);
      chk_read(rv, {31'h0, dbg_pin});
    end
    // Force bits set while functional: outputs must ignore them
    wr(OFS_GLOBAL, 32'h0000_0202);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      @(posedge clk);
      f_s  <= v[0];
      f_ns <= v[1];
      settle(2);
      chk_out({30'h0, g_s, g_ns}, {30'h0, v[0], v[1]});
    end
    wr(OFS_CTRL, ctrl_word(1, 0, 0, 0, 5'h0));
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      if (i < 4) begin
        v[9] = i[0];
        v[1] = i[1];
      end
      @(posedge clk);
      f_s  <= ~v[9];
      f_ns <= ~v[1];
      wr(OFS_GLOBAL, v);
      settle(3);
      chk_out({30'h0, g_s, g_ns}, {30'h0, v[9], v[1]});
      rd(OFS_GLOBAL, rv);
      chk_read(rv, glb_expect(v));
    end
    wr(OFS_CTRL, ctrl_word(0, 0, 0, 0, 5'h0));
    settle(3);
    chk_out({30'h0, g_s, g_ns}, {30'h0, ~v[9], ~v[1]});
    // all 32 buffer units exist here
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_0001 : $urandom;
      wr(OFS_PERF, v);
      settle(2);
      chk_out(en_out, v);
      rd(OFS_PERF, rv);
      chk_read(rv, v);
    end
    v = $urandom;
    rv = $urandom;
    wr(OFS_PERF, v);
    wr(OFS_CTRL, ctrl_word(1, 1, 0, 1, rv[4:0]));
    settle(2);
    chk_out({19'h0, bact, bunit, bidx}, {19'h0, 1'b1, rv[4:0], v[6:0]});
    chk_out(en_out, 32'h0);
    rd(OFS_GLOBAL, rv);
    chk_read(rv & 32'h007f_0000, 32'h0);
    // ----------------------------------------
    // Control-unit RAM and interrupts
    // ----------------------------------------
    wr(OFS_STATUS, 32'h7);
    wr(OFS_CTRL, ctrl_word(1, 1, 1, 0, 5'h0));
    for (int i = 0; i < 3; i++) begin
      v = $urandom;
      ram_d[i] = v[6:0];
      wr(OFS_PERF, ram_index(i));
      wr(OFS_GLOBAL, {9'h0, ram_d[i], 16'h0});
    end
    rd(OFS_STATUS, rv);
    chk_read(rv & 32'h6, 32'h2);
    wr(OFS_CTRL, ctrl_word(1, 1, 0, 0, 5'h0));
    settle(2);
    chk_out({19'h0, bact, bunit, bidx}, 32'h0);
    for (int i = 2; i >= 0; i--) begin
      wr(OFS_PERF, ram_index(i));
      rd(OFS_GLOBAL, rv);
      chk_read(rv & 32'h007f_0000, {9'h0, ram_d[i], 16'h0});
    end
    rd(OFS_STATUS, rv);
    chk_read(rv & 32'h6, 32'h6);
    chk_out({31'h0, irq}, 32'h0);
    wr(OFS_MASK, 32'h4);
    settle(2);
    chk_out({31'h0, irq}, 32'h1);
    wr(OFS_STATUS, 32'h4);
    settle(2);
    chk_out({31'h0, irq}, 32'h0);
    rd(OFS_STATUS, rv);
    chk_read(rv & 32'h6, 32'h2);
    wr(OFS_MASK, 32'h3);
    settle(2);
    chk_out({31'h0, irq}, 32'h1);
    wr(OFS_STATUS, 32'h7);
    settle(2);
    chk_out({31'h0, irq}, 32'h0);
    @(posedge clk);
    dbg_pin <= ~dbg_pin;
    settle(8);
    chk_out({31'h0, irq}, 32'h1);
    wr(OFS_STATUS, 32'h1);
    settle(2);
    chk_out({31'h0, irq}, 32'h0);
    // Unmapped and read-only places ignore writes
    wr(8'h40, $urandom);
    rd(8'h40, rv);
    chk_read(rv, 32'h0);
    wr(OFS_INPUT, 32'hffff_ffff);
    rd(OFS_INPUT, rv);
    chk_read(rv, {31'h0, dbg_pin});
    end_of_test();
  end

endmodule // translation_unit_integration_test_test
